//--- usbe_ep_flags.sv
// Shared constants and the per-endpoint event flag store
package usbe_pkg;
  localparam int NUM_EP = 7;
  localparam int NUM_SLOT = 8;
  localparam int FLAG_W = 7;
  localparam int MEM_BYTES = 312;
  localparam logic [2:0] PINGPONG_EP = 3'h6;
  // Flag positions inside an endpoint status word
  localparam int FLG_IN_DONE = 0;
  localparam int FLG_OUT_B0 = 1;
  localparam int FLG_SETUP = 2;
  localparam int FLG_STALL = 3;
  localparam int FLG_IN_NAK = 4;
  localparam int FLG_OUT_NAK = 5;
  localparam int FLG_OUT_B1 = 6;
  localparam int STATUS_BANK_SWITCH_BIT = 7;
  localparam int STATUS_BANK_BIT = 8;
  localparam int STATUS_COUNT_LSB = 16;
  // Slot 0..5 are endpoints 0..5, slots 6 and 7 the two banks of endpoint 6
  localparam logic [8:0] SLOT_BASE [0:NUM_SLOT-1] = '{9'h000, 9'h020, 9'h028, 9'h030,
                                                     9'h038, 9'h078, 9'h0b8, 9'h0f8};
  localparam logic [6:0] SLOT_SIZE [0:NUM_SLOT-1] = '{7'h20, 7'h08, 7'h08, 7'h08,
                                                     7'h40, 7'h40, 7'h40, 7'h40};
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_GLB_STATUS = 12'h004;
  localparam logic [11:0] REG_GLB_ENABLE = 12'h008;
  localparam logic [11:0] REG_EP_ENABLE = 12'h00c;
  localparam logic [11:0] REG_EP_SELECT = 12'h010;
  localparam logic [11:0] REG_EP_CFG = 12'h014;
  localparam logic [11:0] REG_EP_STATUS = 12'h018;
  localparam logic [11:0] REG_EP_DATA = 12'h01c;
  localparam logic [11:0] REG_EP_SUMMARY = 12'h020;
  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_UPGRADE_BIT = 1;
  localparam int CTRL_PRIO_LOW_BIT = 8;
  localparam int CTRL_PRIO_HIGH_BIT = 9;
  // Global flag positions
  localparam int GLB_SOF = 0;
  localparam int GLB_SUSPEND = 1;
  localparam int GLB_RESUME = 2;
  // Endpoint configuration fields
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_DIR_IN_BIT = 2;
  localparam int CFG_STALL_BIT = 3;
  localparam int CFG_EN_BIT = 4;
  typedef enum logic [1:0] {
    EP_CONTROL = 2'b00,
    EP_BULK = 2'b01,
    EP_INTERRUPT = 2'b10,
    EP_ISO = 2'b11
  } usbe_ep_kind_type;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;
endpackage : usbe_pkg

module usbe_ep_flags #(
  parameter bit PINGPONG = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ev_in_done,
  input wire logic ev_out_b0,
  input wire logic ev_out_b1,
  input wire logic ev_setup,
  input wire logic ev_stall,
  input wire logic ev_in_nak,
  input wire logic ev_out_nak,
  input wire logic [usbe_pkg::FLAG_W-1:0] clr,
  output logic [usbe_pkg::FLAG_W-1:0] flags
);
  import usbe_pkg::*;
  logic [FLAG_W-1:0] set_vec;
  logic [FLAG_W-1:0] hw_clr;

  always_comb begin
    set_vec = '0;
    set_vec[FLG_IN_DONE] = ev_in_done;
    set_vec[FLG_OUT_B0] = ev_out_b0;
    set_vec[FLG_OUT_B1] = ev_out_b1 & PINGPONG;
    set_vec[FLG_SETUP] = ev_setup;
    set_vec[FLG_STALL] = ev_stall;
    set_vec[FLG_IN_NAK] = ev_in_nak;
    set_vec[FLG_OUT_NAK] = ev_out_nak;
    hw_clr = '0;
    hw_clr[FLG_STALL] = ev_setup;
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= (flags & ~(clr | hw_clr)) | set_vec;
    end
  end
endmodule : usbe_ep_flags

//--- usbe_top.sv
// USB device endpoint FIFOs, event flags and AXI4-Lite register file
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
module usbe_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [2:0] SIE_EP,
  input wire logic SIE_RX_VALID,
  input wire logic [7:0] SIE_RX_DATA,
  input wire logic SIE_OUT_DONE,
  input wire logic SIE_SETUP_DONE,
  input wire logic SIE_IN_ACK,
  input wire logic SIE_IN_NAK,
  input wire logic SIE_OUT_NAK,
  input wire logic SIE_STALL_SENT,
  input wire logic SIE_TX_POP,
  input wire logic SIE_SOF,
  input wire logic SIE_SUSPEND,
  input wire logic SIE_RESUME,
  output logic [7:0] SIE_TX_DATA,
  output logic [usbe_pkg::NUM_EP-1:0] EP_IN_READY,
  output logic [usbe_pkg::NUM_EP-1:0] EP_OUT_FREE,
  output logic [usbe_pkg::NUM_EP-1:0] EP_STALL_REQ,
  output logic [usbe_pkg::NUM_EP-1:0] EP_ENABLED,
  output logic DEVICE_ENABLE,
  output logic USB_IRQ,
  output logic [1:0] USB_PRIORITY_LEVEL,
  output logic USB_PRIORITY_HIGH_BIT,
  output logic USB_PRIORITY_LOW_BIT
);
  import usbe_pkg::*;

  logic [7:0] mem_r [0:MEM_BYTES-1];
  logic [6:0] rp_r [0:NUM_SLOT-1];
  logic [6:0] wp_r [0:NUM_SLOT-1];
  logic [6:0] cnt_r [0:NUM_SLOT-1];
  logic [NUM_SLOT-1:0] flush;
  logic [FLAG_W-1:0] flags_w [0:NUM_SLOT-1];
  logic [FLAG_W-1:0] clr_w [0:NUM_SLOT-1];
  usbe_ep_kind_type ep_type_r [0:NUM_SLOT-1];
  logic [NUM_SLOT-1:0] ep_dir_in_r;
  logic [NUM_SLOT-1:0] ep_stall_r;
  logic [NUM_SLOT-1:0] ep_on_r;
  logic [NUM_SLOT-1:0] ep_any;
  logic [NUM_SLOT-1:0] in_ready_w;
  logic [NUM_SLOT-1:0] out_free_w;
  logic enable_r, upgrade_r, prio_hi_r, prio_lo_r;
  logic [2:0] glb_flags_r, glb_en_r, glb_set;
  logic [NUM_EP-1:0] ep_en_r;
  logic [2:0] ep_sel_r;
  logic suspended_r, sie_bank_r, fw_bank_r;
  logic aw_hold_r, w_hold_r, ar_hold_r;
  logic [11:0] aw_addr_r, ar_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [31:0] rd_mux;
  logic rd_hit, wr_hit;
  logic sie_ok, sel_ok, do_wr, do_rd;
  logic [2:0] sie_slot, fw_slot;
  logic rx_wr, fw_wr, tx_rd, fw_rd;
  logic [8:0] wr_addr, tx_addr, fw_rd_addr;
  logic [7:0] wr_byte;
  logic wr_status, bank_switch;

  function automatic logic [2:0] slot_of(input logic [2:0] ep, input logic bank);
    slot_of = (ep == PINGPONG_EP) ? {2'b11, bank} : ep;
  endfunction : slot_of

  // Traffic limited to endpoint zero while upgrading; endpoint zero is always on
  assign sie_ok = enable_r && (SIE_EP < 3'(NUM_EP)) && (ep_on_r[SIE_EP] || SIE_EP == 3'h0)
                  && (!upgrade_r || SIE_EP == 3'h0);
  assign sel_ok = ep_sel_r < 3'(NUM_EP);
  assign sie_slot = slot_of(SIE_EP, sie_bank_r);
  assign fw_slot = slot_of(ep_sel_r, fw_bank_r);

  // Register accesses wait while the engine uses the same FIFO port
  assign do_wr = aw_hold_r && w_hold_r && !S_AXI_BVALID && !SIE_RX_VALID;
  assign do_rd = ar_hold_r && !S_AXI_RVALID && !SIE_TX_POP;
  assign wr_status = do_wr && aw_addr_r == REG_EP_STATUS && w_strb_r[0] && sel_ok;
  assign bank_switch = wr_status && ep_sel_r == PINGPONG_EP && w_data_r[STATUS_BANK_SWITCH_BIT];

  // FIFO ports: engine fills OUT data and drains IN data, firmware the opposite
  assign rx_wr = sie_ok && SIE_RX_VALID && cnt_r[sie_slot] != SLOT_SIZE[sie_slot];
  assign fw_wr = do_wr && aw_addr_r == REG_EP_DATA && w_strb_r[0] && sel_ok
                 && cnt_r[fw_slot] != SLOT_SIZE[fw_slot];
  assign tx_rd = sie_ok && SIE_TX_POP && cnt_r[sie_slot] != 7'h00;
  assign fw_rd = do_rd && ar_addr_r == REG_EP_DATA && sel_ok && cnt_r[fw_slot] != 7'h00;
  assign wr_addr = rx_wr ? SLOT_BASE[sie_slot] + {2'b00, wp_r[sie_slot]}
                         : SLOT_BASE[fw_slot] + {2'b00, wp_r[fw_slot]};
  assign wr_byte = rx_wr ? SIE_RX_DATA : w_data_r[7:0];
  assign tx_addr = SLOT_BASE[sie_slot] + {2'b00, rp_r[sie_slot]};
  assign fw_rd_addr = SLOT_BASE[fw_slot] + {2'b00, rp_r[fw_slot]};

  // Storage has no reset; pointers define what is valid
  always_ff @(posedge CLOCK) begin
    if (rx_wr || fw_wr) begin
      mem_r[wr_addr] <= wr_byte;
    end
  end

  // Per-slot pointers and counts; a slot is released when firmware clears its flag
  genvar s;
  generate
    for (s = 0; s < NUM_SLOT; s++) begin : g_slot
      logic push, pop;
      assign push = (rx_wr && sie_slot == 3'(s)) || (fw_wr && fw_slot == 3'(s));
      assign pop = (tx_rd && sie_slot == 3'(s)) || (fw_rd && fw_slot == 3'(s));
      if (s == NUM_SLOT - 1) begin : g_b1
        assign flush[s] = wr_status && ep_sel_r == PINGPONG_EP && w_data_r[FLG_OUT_B1];
      end else if (s == NUM_SLOT - 2) begin : g_b0
        assign flush[s] = wr_status && ep_sel_r == PINGPONG_EP && w_data_r[FLG_OUT_B0];
      end else begin : g_plain
        assign flush[s] = wr_status && ep_sel_r == 3'(s) && w_data_r[FLG_OUT_B0];
      end
      always_ff @(posedge CLOCK) begin
        if (RST || flush[s]) begin
          rp_r[s] <= 7'h00;
          wp_r[s] <= 7'h00;
          cnt_r[s] <= 7'h00;
        end else begin
          if (push) begin
            wp_r[s] <= (wp_r[s] + 7'h01 == SLOT_SIZE[s]) ? 7'h00 : wp_r[s] + 7'h01;
          end
          if (pop) begin
            rp_r[s] <= (rp_r[s] + 7'h01 == SLOT_SIZE[s]) ? 7'h00 : rp_r[s] + 7'h01;
          end
          if (push && !pop) begin
            cnt_r[s] <= cnt_r[s] + 7'h01;
          end else if (pop && !push) begin
            cnt_r[s] <= cnt_r[s] - 7'h01;
          end
        end
      end
    end
  endgenerate

  // Endpoint event flags, one store per endpoint
  genvar e;
  generate
    for (e = 0; e < NUM_EP; e++) begin : g_ep
      logic hit;
      logic bank1;
      assign hit = sie_ok && SIE_EP == 3'(e);
      assign bank1 = (e == NUM_EP - 1) && sie_bank_r;
      assign clr_w[e] = (wr_status && ep_sel_r == 3'(e)) ? w_data_r[FLAG_W-1:0] : '0;
      usbe_ep_flags #(.PINGPONG(e == NUM_EP - 1)) u_flags (
        .clk(CLOCK),
        .rst(RST),
        .ev_in_done(hit && SIE_IN_ACK),
        .ev_out_b0(hit && SIE_OUT_DONE && !bank1),
        .ev_out_b1(hit && SIE_OUT_DONE && bank1),
        .ev_setup(hit && SIE_SETUP_DONE),
        .ev_stall(hit && SIE_STALL_SENT && ep_stall_r[e] && ep_type_r[e] != EP_ISO),
        .ev_in_nak(hit && SIE_IN_NAK),
        .ev_out_nak(hit && SIE_OUT_NAK),
        .clr(clr_w[e]),
        .flags(flags_w[e])
      );
      assign ep_any[e] = |flags_w[e];
      assign in_ready_w[e] = cnt_r[slot_of(3'(e), sie_bank_r)] != 7'h00;
      assign out_free_w[e] = bank1 ? !flags_w[e][FLG_OUT_B1] : !flags_w[e][FLG_OUT_B0];
    end
  endgenerate
  assign flags_w[NUM_SLOT-1] = '0;
  assign clr_w[NUM_SLOT-1] = '0;
  assign ep_any[NUM_SLOT-1] = 1'b0;
  assign in_ready_w[NUM_SLOT-1] = 1'b0;
  assign out_free_w[NUM_SLOT-1] = 1'b0;

  // Ping-pong bank ownership; engine and firmware each walk their own bank
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sie_bank_r <= 1'b0;
      fw_bank_r <= 1'b0;
    end else begin
      if (sie_ok && SIE_EP == PINGPONG_EP && (SIE_OUT_DONE || SIE_IN_ACK)) begin
        sie_bank_r <= !sie_bank_r;
      end
      if (flush[{2'b11, fw_bank_r}] || bank_switch) begin
        fw_bank_r <= !fw_bank_r;
      end
    end
  end

  // Bus events; resume only counts after a suspend
  assign glb_set = {SIE_RESUME && suspended_r, SIE_SUSPEND, SIE_SOF} & {3{enable_r}};
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      glb_flags_r <= 3'h0;
      suspended_r <= 1'b0;
    end else begin
      glb_flags_r <= (glb_flags_r & ~((do_wr && aw_addr_r == REG_GLB_STATUS && w_strb_r[0])
                     ? w_data_r[2:0] : 3'h0)) | glb_set;
      if (SIE_SUSPEND) begin
        suspended_r <= 1'b1;
      end else if (SIE_RESUME) begin
        suspended_r <= 1'b0;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      enable_r <= 1'b0;
      upgrade_r <= 1'b0;
      prio_hi_r <= 1'b0;
      prio_lo_r <= 1'b0;
      glb_en_r <= 3'h0;
      ep_en_r <= '0;
      ep_sel_r <= 3'h0;
      ep_dir_in_r <= '0;
      ep_stall_r <= '0;
      ep_on_r <= '0;
      for (int i = 0; i < NUM_SLOT; i++) begin
        ep_type_r[i] <= EP_CONTROL;
      end
    end else if (do_wr) begin
      if (aw_addr_r == REG_CTRL && w_strb_r[0]) begin
        enable_r <= w_data_r[CTRL_EN_BIT];
        upgrade_r <= w_data_r[CTRL_UPGRADE_BIT];
      end
      if (aw_addr_r == REG_CTRL && w_strb_r[1]) begin
        prio_hi_r <= w_data_r[CTRL_PRIO_HIGH_BIT];
        prio_lo_r <= w_data_r[CTRL_PRIO_LOW_BIT];
      end
      if (aw_addr_r == REG_GLB_ENABLE && w_strb_r[0]) begin
        glb_en_r <= w_data_r[2:0];
      end
      if (aw_addr_r == REG_EP_ENABLE && w_strb_r[0]) begin
        ep_en_r <= w_data_r[NUM_EP-1:0];
      end
      if (aw_addr_r == REG_EP_SELECT && w_strb_r[0]) begin
        ep_sel_r <= w_data_r[2:0];
      end
      // Endpoint zero stays a control endpoint
      if (aw_addr_r == REG_EP_CFG && w_strb_r[0] && sel_ok) begin
        ep_type_r[ep_sel_r] <= (ep_sel_r == 3'h0) ? EP_CONTROL
                               : usbe_ep_kind_type'(w_data_r[CFG_TYPE_LSB +: 2]);
        ep_dir_in_r[ep_sel_r] <= w_data_r[CFG_DIR_IN_BIT];
        ep_stall_r[ep_sel_r] <= w_data_r[CFG_STALL_BIT];
        ep_on_r[ep_sel_r] <= w_data_r[CFG_EN_BIT];
      end
    end
  end

  // Outputs toward the engine and the CPU, all registered
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SIE_TX_DATA <= 8'h00;
      EP_IN_READY <= '0;
      EP_OUT_FREE <= '0;
      EP_STALL_REQ <= '0;
      EP_ENABLED <= '0;
      DEVICE_ENABLE <= 1'b0;
      USB_IRQ <= 1'b0;
      USB_PRIORITY_LEVEL <= 2'b00;
      USB_PRIORITY_HIGH_BIT <= 1'b0;
      USB_PRIORITY_LOW_BIT <= 1'b0;
    end else begin
      if (tx_rd) begin
        SIE_TX_DATA <= mem_r[tx_addr];
      end
      EP_IN_READY <= in_ready_w[NUM_EP-1:0];
      EP_OUT_FREE <= out_free_w[NUM_EP-1:0];
      EP_STALL_REQ <= ep_stall_r[NUM_EP-1:0] & ep_on_r[NUM_EP-1:0];
      EP_ENABLED <= ep_on_r[NUM_EP-1:0] | {{(NUM_EP-1){1'b0}}, 1'b1};
      DEVICE_ENABLE <= enable_r;
      USB_IRQ <= |(ep_any[NUM_EP-1:0] & ep_en_r) | |(glb_flags_r & glb_en_r);
      USB_PRIORITY_LEVEL <= {prio_hi_r, prio_lo_r};
      USB_PRIORITY_HIGH_BIT <= prio_hi_r;
      USB_PRIORITY_LOW_BIT <= prio_lo_r;
    end
  end

  // Write channels: address and data taken independently, response after both
  assign wr_hit = aw_addr_r <= REG_EP_SUMMARY && aw_addr_r[1:0] == 2'b00
                  && aw_addr_r != REG_EP_SUMMARY;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (S_AXI_AWREADY && S_AXI_AWVALID) begin
        S_AXI_AWREADY <= 1'b0;
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end else if (!aw_hold_r) begin
        S_AXI_AWREADY <= 1'b1;
      end
      if (S_AXI_WREADY && S_AXI_WVALID) begin
        S_AXI_WREADY <= 1'b0;
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end else if (!w_hold_r) begin
        S_AXI_WREADY <= 1'b1;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read side; a data read pops one byte, an empty FIFO reads zero
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (ar_addr_r)
      REG_CTRL: rd_mux = {22'h0, prio_hi_r, prio_lo_r, 6'h0, upgrade_r, enable_r};
      REG_GLB_STATUS: rd_mux = {29'h0, glb_flags_r};
      REG_GLB_ENABLE: rd_mux = {29'h0, glb_en_r};
      REG_EP_ENABLE: rd_mux = {25'h0, ep_en_r};
      REG_EP_SELECT: rd_mux = {29'h0, ep_sel_r};
      REG_EP_CFG: rd_mux = {27'h0, ep_on_r[ep_sel_r] || ep_sel_r == 3'h0,
                            ep_stall_r[ep_sel_r], ep_dir_in_r[ep_sel_r], ep_type_r[ep_sel_r]};
      REG_EP_STATUS: rd_mux = sel_ok ? {9'h0, cnt_r[fw_slot], 7'h0, fw_bank_r, 1'b0,
                                        flags_w[ep_sel_r]} : 32'h0000_0000;
      REG_EP_DATA: rd_mux = fw_rd ? {24'h0, mem_r[fw_rd_addr]} : 32'h0000_0000;
      REG_EP_SUMMARY: rd_mux = {25'h0, ep_any[NUM_EP-1:0]};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
      ar_hold_r <= 1'b0;
      ar_addr_r <= 12'h000;
    end else begin
      if (S_AXI_ARREADY && S_AXI_ARVALID) begin
        S_AXI_ARREADY <= 1'b0;
        ar_hold_r <= 1'b1;
        ar_addr_r <= S_AXI_ARADDR;
      end else if (!ar_hold_r) begin
        S_AXI_ARREADY <= 1'b1;
      end
      if (do_rd) begin
        ar_hold_r <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule : usbe_top

//--- usbe_top_props.sv
// Port checker for the endpoint flag and FIFO block
module usbe_top_props
  import usbe_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [NUM_EP-1:0] EP_STALL_REQ,
  input wire logic [NUM_EP-1:0] EP_ENABLED,
  input wire logic USB_IRQ,
  input wire logic [1:0] USB_PRIORITY_LEVEL,
  input wire logic USB_PRIORITY_HIGH_BIT,
  input wire logic USB_PRIORITY_LOW_BIT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  prio_match_a: assert property (
    USB_PRIORITY_LEVEL == {USB_PRIORITY_HIGH_BIT, USB_PRIORITY_LOW_BIT})
    else $error("priority bits disagree");
  bresp_hold_a: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  write_answer_a: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:8] S_AXI_BVALID)
    else $error("write not answered");
  read_answer_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:8] S_AXI_RVALID)
    else $error("read not answered");
  // Flags clear by a write, the stall flag also on a setup event; the request falls one cycle after its response rises
  irq_clear_a: assert property (
    $fell(USB_IRQ) |-> $past(S_AXI_BVALID) || $past(RST))
    else $error("interrupt fell without a write");
  stall_gate_a: assert property (
    (EP_STALL_REQ & ~EP_ENABLED) == '0)
    else $error("stall requested on disabled endpoint");
  ep0_alive_a: assert property (
    !$past(RST) && !$past(RST, 2) && !$past(RST, 3) |-> EP_ENABLED[0])
    else $error("control endpoint not enabled");
  cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
  cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
  cover property ($rose(USB_IRQ));
  cover property (|EP_STALL_REQ);
endmodule : usbe_top_props

bind usbe_top usbe_top_props chk_u (.CLOCK, .RST, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
  .S_AXI_RREADY, .EP_STALL_REQ, .EP_ENABLED, .USB_IRQ, .USB_PRIORITY_LEVEL,
  .USB_PRIORITY_HIGH_BIT, .USB_PRIORITY_LOW_BIT);

//--- usbe_host_model.sv
// Behavioural bus-side engine model issuing packet events
module usbe_host_model (
  input wire logic CLOCK,
  output logic [2:0] SIE_EP,
  output logic SIE_RX_VALID,
  output logic [7:0] SIE_RX_DATA,
  output logic SIE_TX_POP,
  output logic [8:0] ev
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    SIE_EP = 3'h0;
    SIE_RX_VALID = 1'b0;
    SIE_RX_DATA = 8'h00;
    SIE_TX_POP = 1'b0;
    ev = '0;
  end
  // Handshakes and bus events, one cycle wide
  task automatic pulse(input int k, input logic [2:0] ep);
    @(posedge CLOCK);
    SIE_EP <= ep;
    ev[k] <= 1'b1;
    @(posedge CLOCK);
    ev[k] <= 1'b0;
  endtask : pulse
  task automatic out_pkt(input logic [2:0] ep, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge CLOCK);
      SIE_EP <= ep;
      SIE_RX_VALID <= 1'b1;
      SIE_RX_DATA <= 8'(i + 1);
    end
    @(posedge CLOCK);
    SIE_RX_VALID <= 1'b0;
    // Stale byte not left on the lines
    SIE_RX_DATA <= ~SIE_RX_DATA;
    pulse(0, ep);
  endtask : out_pkt
  task automatic pop(input logic [2:0] ep);
    @(posedge CLOCK);
    SIE_EP <= ep;
    SIE_TX_POP <= 1'b1;
    @(posedge CLOCK);
    SIE_TX_POP <= 1'b0;
  endtask : pop
endmodule : usbe_host_model

//--- usbe_top_tb.sv
// Self-checking bench for the endpoint flag and FIFO block
module usbe_top_tb import usbe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq, rxv, pop, den;
  logic [1:0] bresp, rrs, prio;
  logic [7:0] txd, rxd;
  logic [2:0] sep;
  logic [8:0] ev;
  logic [NUM_EP-1:0] inrdy, stl, ofree;
  logic [2:0] eps [3] = '{3'h0, 3'h1, 3'h4};
  logic [6:0] szs [3] = '{7'h20, 7'h08, 7'h40};
  int err_count = 0, checked = 0;
  always #25 CLOCK = ~CLOCK;
  usbe_host_model host_u (.CLOCK, .SIE_EP(sep), .SIE_RX_VALID(rxv), .SIE_RX_DATA(rxd),
    .SIE_TX_POP(pop), .ev(ev));
  usbe_top dut_u (.CLOCK, .RST, .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SIE_EP(sep), .SIE_RX_VALID(rxv), .SIE_RX_DATA(rxd), .SIE_OUT_DONE(ev[0]),
    .SIE_SETUP_DONE(ev[1]), .SIE_IN_ACK(ev[2]), .SIE_IN_NAK(ev[3]), .SIE_OUT_NAK(ev[4]),
    .SIE_STALL_SENT(ev[5]), .SIE_TX_POP(pop), .SIE_SOF(ev[6]), .SIE_SUSPEND(ev[7]),
    .SIE_RESUME(ev[8]), .SIE_TX_DATA(txd), .EP_IN_READY(inrdy), .EP_OUT_FREE(ofree),
    .EP_STALL_REQ(stl), .EP_ENABLED(), .DEVICE_ENABLE(den), .USB_IRQ(irq),
    .USB_PRIORITY_LEVEL(prio), .USB_PRIORITY_HIGH_BIT(), .USB_PRIORITY_LOW_BIT());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge CLOCK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge CLOCK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rrs), 32'(er));
  endtask : rdc
  task automatic sel(input logic [2:0] ep, input logic [4:0] cfg);
    wr(REG_EP_SELECT, 32'(ep));
    wr(REG_EP_CFG, 32'(cfg));
  endtask : sel
  task automatic end_sim;
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    wr(REG_CTRL, 32'h1);
    wr(REG_GLB_ENABLE, 32'h7);
    host_u.pulse(8, 3'h0);
    host_u.pulse(6, 3'h0);
    rdc(REG_GLB_STATUS, 32'h1);
    chk(32'(den), 32'h1);
    chk(32'(irq), 32'h1);
    host_u.pulse(7, 3'h0);
    host_u.pulse(8, 3'h0);
    rdc(REG_GLB_STATUS, 32'h7);
    wr(REG_GLB_STATUS, 32'h7);
    rdc(REG_GLB_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(REG_CTRL, {22'h0, 2'(p), 8'h01});
      // Level output lags the write by one edge
      @(negedge CLOCK);
      chk(32'(prio), 32'(p));
    end
    // Overfill each size class by two bytes
    for (int k = 0; k < 3; k++) begin
      sel(eps[k], 5'h11);
      host_u.out_pkt(eps[k], int'(szs[k]) + 2);
      rdc(REG_EP_STATUS, {9'h0, szs[k], 16'h0002});
      chk(32'(ofree[eps[k]]), 32'h0);
      rdc(REG_EP_DATA, 32'h1);
      wr(REG_EP_STATUS, 32'h2);
      rdc(REG_EP_STATUS, 32'h0);
      chk(32'(ofree[eps[k]]), 32'h1);
    end
    sel(3'h6, 5'h11);
    host_u.out_pkt(3'h6, 2);
    host_u.out_pkt(3'h6, 3);
    rdc(REG_EP_STATUS, 32'h0002_0042);
    wr(REG_EP_STATUS, 32'h2);
    rdc(REG_EP_STATUS, 32'h0003_0140);
    wr(REG_EP_STATUS, 32'h40);
    rdc(REG_EP_STATUS, 32'h0);
    sel(3'h1, 5'h18);
    @(negedge CLOCK);
    chk(32'(stl[1]), 32'h1);
    host_u.pulse(5, 3'h1);
    rdc(REG_EP_STATUS, 32'h8);
    host_u.pulse(1, 3'h1);
    rdc(REG_EP_STATUS, 32'h4);
    wr(REG_EP_STATUS, 32'h4);
    sel(3'h2, 5'h10);
    wr(REG_EP_ENABLE, 32'h4);
    host_u.pulse(3, 3'h2);
    host_u.pulse(4, 3'h2);
    rdc(REG_EP_STATUS, 32'h30);
    chk(32'(irq), 32'h1);
    rdc(REG_EP_STATUS, 32'h30);
    wr(REG_EP_STATUS, 32'h30);
    rdc(REG_EP_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    sel(3'h5, 5'h15);
    wr(REG_EP_DATA, 32'ha1);
    wr(REG_EP_DATA, 32'ha2);
    chk(32'(inrdy[5]), 32'h1);
    for (int i = 0; i < 2; i++) begin
      host_u.pop(3'h5);
      @(negedge CLOCK);
      chk(32'(txd), 32'ha1 + 32'(i));
    end
    host_u.pulse(2, 3'h5);
    rdc(REG_EP_STATUS, 32'h1);
    wr(REG_CTRL, 32'h3);
    host_u.pulse(4, 3'h5);
    rdc(REG_EP_STATUS, 32'h1);
    wr(REG_EP_SELECT, 32'h0);
    host_u.pulse(4, 3'h0);
    rdc(REG_EP_STATUS, 32'h20);
    wr(REG_EP_SUMMARY, 32'h0, RESP_SLVERR);
    rdc(12'h0fc, 32'h0, RESP_SLVERR);
    end_sim;
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge CLOCK);
    err_count++;
    end_sim;
  end
endmodule : usbe_top_tb
